// File: bench/evp_checker.sv
// Checker: timing and value relations at the exception unit's ports.
// Assumes one clock domain; attached to the design top by bind.
`timescale 1ns/1ps
module evp_checker #(
  parameter PAR_W = 8,
  parameter AW = 64
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Watched ports
  input wire exc_valid,
  input wire [20:0] exc_req,
  input wire mode64,
  input wire fill,
  input wire exc_taken,
  input wire [4:0] exc_code,
  input wire [AW-1:0] vector_addr,
  input wire kernel_mode,
  input wire [1:0] priv_mode,
  input wire [PAR_W-1:0] fill_parity
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  function automatic [4:0] first_code(input [20:0] r);
    first_code = 5'h1F;
    for (int i = 20; i >= 0; i--)
      if (r[i]) first_code = 5'(i + 1);
  endfunction
  // Skip the first edge: the pending cold reset wins there
  sequence s_take;
    exc_valid && (|exc_req) && $past(hresetn);
  endsequence
  a_take_next: assert property (s_take |=> exc_taken)
    else $error("request not taken");
  a_take_cause: assert property (exc_taken |->
    $past(exc_valid && (|exc_req)) || !$past(hresetn, 2))
    else $error("take without request");
  a_prio_code: assert property (s_take |=>
    exc_code == $past(first_code(exc_req))) else $error("wrong priority");
  a_reset_vec: assert property (exc_taken && exc_code <= 5'h02 |->
    vector_addr[31:0] == 32'hBFC0_0000) else $error("reset vector");
  a_cache_ofs: assert property (exc_taken && exc_code inside {6, 18} |->
    vector_addr[8:0] == 9'h100) else $error("cache vector offset");
  a_other_ofs: assert property (exc_taken && exc_code > 5'h02 &&
    !(exc_code inside {4, 6, 15, 18}) |-> vector_addr[8:0] == 9'h180)
    else $error("general vector offset");
  a_upper_sign: assert property (exc_taken |->
    vector_addr[63:32] == {32{$past(mode64)}}) else $error("sign extension");
  a_level_kernel: assert property (s_take |=> ##1
    kernel_mode && priv_mode == 2'b00) else $error("not kernel mode");
  a_fill_hold: assert property (!fill |=> $stable(fill_parity))
    else $error("fill parity moved");
endmodule // evp_checker
bind evp_exception_unit evp_checker #(.PAR_W(PAR_W), .AW(AW))
  evp_checker_i (.*);

// File: bench/evp_pipe.sv
// Partner: pipeline and cache side raising requests and events.
// Assumes its tasks are called just after a rising edge of hclk.
`timescale 1ns/1ps
module evp_pipe (
  // Clock
  input wire hclk,
  // Exception requests
  output logic exc_valid,
  output logic [20:0] exc_req,
  output logic refill_space64,
  output logic mode64,
  output logic [63:0] exc_pc,
  output logic [63:0] branch_pc,
  output logic in_delay_slot,
  output logic eret,
  // Cache and bus events
  output logic tag_load,
  output logic tag_load_dcache,
  output logic [7:0] stored_parity,
  output logic fill,
  output logic [7:0] computed_parity,
  output logic cache_err,
  output logic cache_err_data_ref,
  output logic cache_err_data_field,
  output logic cache_err_tag_field,
  output logic [10:0] cache_err_index,
  output logic bus_err
);
  initial begin
    {exc_valid, exc_req, refill_space64, mode64, exc_pc, branch_pc} = '0;
    {in_delay_slot, eret, tag_load, tag_load_dcache, stored_parity} = '0;
    {fill, computed_parity, cache_err, cache_err_data_ref} = '0;
    {cache_err_data_field, cache_err_tag_field, cache_err_index} = '0;
    bus_err = 1'b0;
  end
  task take(input [20:0] r, input [63:0] pc, bpc, input ds, s64, m64);
    exc_valid <= 1'b1;
    exc_req <= r;
    {exc_pc, branch_pc, in_delay_slot, refill_space64} <= {pc, bpc, ds, s64};
    mode64 <= m64;
    @(posedge hclk);
    exc_valid <= 1'b0;
    // Unqualified lines must not keep a stale request
    {exc_req, exc_pc} <= ~{r, pc};
  endtask
  task ret;
    eret <= 1'b1;
    @(posedge hclk);
    eret <= 1'b0;
  endtask
  // f holds bus, reference type, data field, tag field
  task cerr(input [3:0] f, input [10:0] idx);
    {bus_err, cache_err_data_ref, cache_err_data_field} <= f[3:1];
    cache_err_tag_field <= f[0];
    cache_err <= |f[2:0];
    cache_err_index <= idx;
    @(posedge hclk);
    {bus_err, cache_err} <= 2'b00;
  endtask
  task tload(input dc, input [7:0] p);
    {tag_load, tag_load_dcache, stored_parity} <= {1'b1, dc, p};
    @(posedge hclk);
    {tag_load, stored_parity} <= {1'b0, ~p};
  endtask
  task fillp(input [7:0] p);
    {fill, computed_parity} <= {1'b1, p};
    @(posedge hclk);
    {fill, computed_parity} <= {1'b0, ~p};
  endtask
endmodule // evp_pipe

// File: bench/tb_top.sv
// Testbench: AHB-Lite master, pipeline partner and scoreboard.
// Assumes zero wait states and exc_taken one cycle after a take.
`timescale 1ns/1ps
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, hready, exc_valid, refill_space64, mode64;
  wire in_delay_slot, eret, tag_load, tag_load_dcache, fill, bus_err;
  wire cache_err, cache_err_data_ref, cache_err_data_field;
  wire cache_err_tag_field, exc_taken, kernel_mode;
  wire [20:0] exc_req;
  wire [63:0] exc_pc, branch_pc, vector_addr;
  wire [7:0] stored_parity, computed_parity, fill_parity;
  wire [10:0] cache_err_index;
  wire [4:0] exc_code;
  wire [1:0] priv_mode;
  assign hready = hreadyout;
  evp_exception_unit #(.PAR_W(8), .AW(64)) evp_exception_unit_i (.*);
  evp_pipe evp_pipe_i (.*);
  logic [68:0] q_exc[$];
  logic [31:0] q_rd[$];
  int err_count = 0, checks_done = 0, cyc = 0, k;
  int seed = 32'hf24e362d;
  logic dph = 0, boot_vector_select, error_level_bit, exception_level_bit, ds, s64, m64;
  logic [63:0] era = 0, pc, bpc;
  logic [20:0] r;
  logic [31:0] st;
  logic [68:0] exp_e;
  logic [31:0] exp_r;
  initial forever #4 hclk = ~hclk;
  task cmp(input logic [68:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_exc(input logic [68:0] got, exp);
    cmp(got, exp);
  endtask
  task cmp_rd(input logic [31:0] got, exp);
    cmp({37'h0, got}, {37'h0, exp});
  endtask
  task cmp_pin(input logic [7:0] got, exp);
    cmp({61'h0, got}, {61'h0, exp});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (exc_taken === 1'b1) begin
      exp_e = q_exc.size() ? q_exc.pop_front() : 'x;
      cmp_exc({exc_code, vector_addr}, exp_e);
    end
    if (dph) begin
      exp_r = q_rd.size() ? q_rd.pop_front() : 'x;
      cmp_rd(hrdata, exp_r);
      cmp_pin({7'h00, hresp}, 8'h00);
    end
    dph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, w, 3'h2};
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [68:0] ev(int k, logic boot_vector_select, exception_level_bit, s64, m64);
    logic [31:0] lo;
    lo = boot_vector_select ? 32'hBFC0_0200 : 32'h8000_0000;
    if (k == 5 || k == 17)
      lo = (boot_vector_select ? 32'hBFC0_0200 : 32'hA000_0000) + 32'h0000_0100;
    else if ((k == 3 || k == 14) && !exception_level_bit)
      lo = lo + (s64 ? 32'h0000_0080 : 32'h0000_0000);
    else
      lo = lo + 32'h0000_0180;
    if (k < 2) lo = 32'hBFC0_0000;
    ev = {5'(k + 1), {32{m64}}, lo};
  endfunction
  initial begin
    q_exc.push_back(ev(-1, 1'b1, 1'b0, 1'b0, 1'b0));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(8'h10, 32'h0000_0006);
    $display("cold reset test done");
    for (int i = 0; i < 42; i++) begin
      k = i % 21;
      st = $random(seed);
      {boot_vector_select, error_level_bit, exception_level_bit, ds, s64, m64} = st[5:0];
      bus(1'b1, 8'h10, {29'h0000_0000, boot_vector_select, error_level_bit, exception_level_bit});
      r = 21'($random(seed)) << k;
      r[k] = 1'b1;
      pc = {$random(seed), $random(seed)};
      bpc = {$random(seed), $random(seed)};
      q_exc.push_back(ev(k, boot_vector_select, exception_level_bit, s64, m64));
      if ((k < 2 || k == 5 || k == 17) && !error_level_bit) era = ds ? bpc : pc;
      evp_pipe_i.take(r, pc, bpc, ds, s64, m64);
      @(posedge hclk);
      rd(8'h08, era[31:0]);
      rd(8'h0C, era[63:32]);
      if (k < 2) {boot_vector_select, error_level_bit} = 2'b11;
      else if (k == 5 || k == 17) error_level_bit = 1'b1;
      else exception_level_bit = 1'b1;
      if (st[6]) evp_pipe_i.ret();
      if (st[6]) exception_level_bit = 1'b0;
      rd(8'h10, {29'h0000_0000, boot_vector_select, error_level_bit, exception_level_bit});
    end
    $display("priority and vector test done");
    bus(1'b1, 8'h04, 32'h0000_0000);
    evp_pipe_i.cerr(4'b0010, 11'h5A5);
    rd(8'h04, 32'h2000_05A5);
    evp_pipe_i.cerr(4'b0101, 11'h123);
    rd(8'h04, 32'h2200_05A5);
    evp_pipe_i.cerr(4'b1000, 11'h000);
    rd(8'h04, 32'h2600_05A5);
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'hB600_07FF);
    rd(8'h20, 32'h0000_0000);
    $display("cache error test done");
    bus(1'b1, 8'h10, 32'h0000_0020);
    evp_pipe_i.tload(1'b1, 8'hA5);
    rd(8'h00, 32'h0000_00A5);
    evp_pipe_i.tload(1'b0, 8'hA5);
    rd(8'h00, 32'h0000_0001);
    evp_pipe_i.fillp(8'h3C);
    @(posedge hclk);
    cmp_pin(fill_parity, 8'h01);
    bus(1'b1, 8'h10, 32'h0000_0010);
    evp_pipe_i.fillp(8'h3C);
    @(posedge hclk);
    cmp_pin(fill_parity, 8'h3C);
    cmp_pin({5'h00, kernel_mode, priv_mode}, 8'h02);
    $display("parity and mode test done");
    repeat (3) @(posedge hclk);
    cmp_pin(8'(q_exc.size() + q_rd.size()), 8'h00);
    end_sim();
  end
endmodule // tb_top

// File: common/evp_consts.vh
// Constants for the exception vector and priority unit.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef EVP_CONSTS_VH
`define EVP_CONSTS_VH

// Register byte offsets
`define EVP_OFF_PARITY 8'h00
`define EVP_OFF_CERR 8'h04
`define EVP_OFF_ERA_LO 8'h08
`define EVP_OFF_ERA_HI 8'h0C
`define EVP_OFF_STAT 8'h10
`define EVP_OFF_VEC_LO 8'h14
`define EVP_OFF_VEC_HI 8'h18
`define EVP_OFF_CODE 8'h1C

// Cache error status fields
`define EVP_CE_REF 31
`define EVP_CE_DATA 29
`define EVP_CE_TAG 28
`define EVP_CE_BUS 26
`define EVP_CE_BOTH 25
`define EVP_CE_IDX_W 11
`define EVP_CE_MASK 32'hB600_07FF

// Status control fields
`define EVP_ST_EXL 0
`define EVP_ST_ERL 1
`define EVP_ST_BEV 2
`define EVP_ST_PRIV_LO 3
`define EVP_ST_DIAG 5

// Reset values
`define EVP_STAT_RST 3'h6
`define EVP_PRIV_KERNEL 2'h0

// Vector bases and offsets
`define EVP_BASE_RESET 32'hBFC0_0000
`define EVP_BASE_GEN0 32'h8000_0000
`define EVP_BASE_CER0 32'hA000_0000
`define EVP_BASE_BEV1 32'hBFC0_0200
`define EVP_OFS_REFILL32 32'h0000_0000
`define EVP_OFS_REFILL64 32'h0000_0080
`define EVP_OFS_CERR 32'h0000_0100
`define EVP_OFS_OTHER 32'h0000_0180
`define EVP_SIGN_HI 32'hFFFF_FFFF

// Request bit positions, highest priority first
`define EVP_NREQ 21
`define EVP_R_SOFT 0
`define EVP_R_NMI 1
`define EVP_R_IREFILL 3
`define EVP_R_ICACHE 5
`define EVP_R_DREFILL 14
`define EVP_R_DCACHE 17
`define EVP_CODE_COLD 5'h00
`define EVP_CODE_NONE 5'h1F

`endif

// File: hw/evp_exception_unit.v
// Exception vector, priority and error-state logic of the coprocessor.
// Assumes the pipeline presents per-instruction requests with a strobe,
// and the cache and bus logic pulse their events for one cycle.
`timescale 1ns/1ps
`include "evp_consts.vh"

module evp_exception_unit #(
  parameter PAR_W = 8,
  parameter AW = 64
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Pipeline exception requests
  input wire exc_valid,
  input wire [20:0] exc_req,
  input wire refill_space64,
  input wire mode64,
  input wire [AW-1:0] exc_pc,
  input wire [AW-1:0] branch_pc,
  input wire in_delay_slot,
  input wire eret,
  // Cache maintenance
  input wire tag_load,
  input wire tag_load_dcache,
  input wire [PAR_W-1:0] stored_parity,
  input wire fill,
  input wire [PAR_W-1:0] computed_parity,
  // Cache and bus error events
  input wire cache_err,
  input wire cache_err_data_ref,
  input wire cache_err_data_field,
  input wire cache_err_tag_field,
  input wire [10:0] cache_err_index,
  input wire bus_err,
  // Results
  output reg exc_taken,
  output reg [4:0] exc_code,
  output reg [AW-1:0] vector_addr,
  output reg kernel_mode,
  output reg [1:0] priv_mode,
  output reg [PAR_W-1:0] fill_parity
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Code reported for request bit n; code zero is the cold reset
  function [4:0] req_code;
    input integer n;
    reg [31:0] v;
    begin
      v = n + 1;
      req_code = v[4:0];
    end
  endfunction

  // Lowest set bit wins: index order is the priority order
  function [4:0] prio_pick;
    input [20:0] req;
    integer i;
    begin
      prio_pick = `EVP_CODE_NONE;
      for (i = `EVP_NREQ - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
          prio_pick = req_code(i);
        end
      end
    end
  endfunction

  // Upper word copies the mode: all ones in 64-bit mode
  function [AW-1:0] sext;
    input [31:0] a;
    input m64;
    begin
      sext = {(m64 ? `EVP_SIGN_HI : 32'h0000_0000), a};
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [PAR_W-1:0] parity_q;
  reg [31:0] cerr_q;
  reg [AW-1:0] era_q;
  reg exl_q;
  reg erl_q;
  reg bev_q;
  reg diag_q;
  reg [1:0] priv_q;
  reg cold_pend_q;
  reg wr_q;
  reg [7:0] wa_q;

  // ----------------------------------------------------------------
  // Exception selection
  // ----------------------------------------------------------------
  // Cold exception stays pending for one cycle after reset release
  wire [4:0] pick = prio_pick(exc_req);
  wire take = cold_pend_q | (exc_valid & (pick != `EVP_CODE_NONE));
  wire [4:0] code = cold_pend_q ? `EVP_CODE_COLD : pick;
  wire is_reset = cold_pend_q | (code == req_code(`EVP_R_SOFT)) |
                  (code == req_code(`EVP_R_NMI));
  wire is_cerr = (code == req_code(`EVP_R_ICACHE)) |
                 (code == req_code(`EVP_R_DCACHE));
  wire is_refill = (code == req_code(`EVP_R_IREFILL)) |
                   (code == req_code(`EVP_R_DREFILL));
  wire err_class = is_reset | is_cerr;

  // Reset-class vectors ignore the boot select; the refill offsets
  // apply only while the exception level is clear
  reg [31:0] base;
  reg [31:0] ofs;
  always @* begin
    if (is_reset) begin
      base = `EVP_BASE_RESET;
      ofs = `EVP_OFS_REFILL32;
    end else if (is_cerr) begin
      base = bev_q ? `EVP_BASE_BEV1 : `EVP_BASE_CER0;
      ofs = `EVP_OFS_CERR;
    end else begin
      base = bev_q ? `EVP_BASE_BEV1 : `EVP_BASE_GEN0;
      if (is_refill && !exl_q) begin
        ofs = refill_space64 ? `EVP_OFS_REFILL64
                             : `EVP_OFS_REFILL32;
      end else begin
        ofs = `EVP_OFS_OTHER;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only whole-word transfers are expected; hsize is not decoded
  wire acc = hsel & htrans[1] & hready;
  wire wr_now = wr_q;
  wire [31:0] wd = hwdata;

  // Read data is muxed in the address phase, so a read right behind
  // a write to the same register still returns the old value
  reg [31:0] rd;
  always @* begin
    case (haddr[7:0])
      `EVP_OFF_PARITY: rd = {{(32 - PAR_W){1'b0}}, parity_q};
      `EVP_OFF_CERR: rd = cerr_q & `EVP_CE_MASK;
      `EVP_OFF_ERA_LO: rd = era_q[31:0];
      `EVP_OFF_ERA_HI: rd = era_q[AW-1:32];
      `EVP_OFF_STAT: rd = {26'h000_0000, diag_q, priv_q, bev_q,
                           erl_q, exl_q};
      `EVP_OFF_VEC_LO: rd = vector_addr[31:0];
      `EVP_OFF_VEC_HI: rd = vector_addr[AW-1:32];
      `EVP_OFF_CODE: rd = {27'h000_0000, exc_code};
      default: rd = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q <= acc & hwrite;
      if (acc) begin
        wa_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parity holding and fill substitution
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      parity_q <= {PAR_W{1'b0}};
      fill_parity <= {PAR_W{1'b0}};
    end else begin
      if (tag_load) begin
        if (tag_load_dcache) begin
          parity_q <= stored_parity;
        end else begin
          parity_q <= {{(PAR_W - 1){1'b0}}, stored_parity[0]};
        end
      end else if (wr_now && wa_q == `EVP_OFF_PARITY) begin
        parity_q <= wd[PAR_W-1:0];
      end
      if (fill) begin
        fill_parity <= diag_q ? parity_q : computed_parity;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cache error status: report only, no correction path
  // ----------------------------------------------------------------
  // Held instruction error: a later data error only marks both
  wire held_ierr = !cerr_q[`EVP_CE_REF] &
                   (cerr_q[`EVP_CE_DATA] | cerr_q[`EVP_CE_TAG]);
  reg [31:0] cerr_d;
  always @* begin
    cerr_d = cerr_q;
    if (wr_now && wa_q == `EVP_OFF_CERR) begin
      cerr_d = wd & `EVP_CE_MASK;
    end
    if (cache_err) begin
      if (held_ierr && cache_err_data_ref) begin
        cerr_d[`EVP_CE_BOTH] = 1'b1;
      end else begin
        cerr_d[`EVP_CE_REF] = cache_err_data_ref;
        cerr_d[`EVP_CE_DATA] = cache_err_data_field;
        cerr_d[`EVP_CE_TAG] = cache_err_tag_field;
        cerr_d[`EVP_CE_IDX_W-1:0] = cache_err_index;
      end
    end
    if (bus_err) begin
      cerr_d[`EVP_CE_BUS] = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cerr_q <= 32'h0000_0000;
    end else begin
      cerr_q <= cerr_d & `EVP_CE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Level bits, privilege and restart address
  // ----------------------------------------------------------------
  // Later assignments win: a take beats eret and a software write
  wire st_wr = wr_now && wa_q == `EVP_OFF_STAT;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {bev_q, erl_q, exl_q} <= `EVP_STAT_RST;
      priv_q <= `EVP_PRIV_KERNEL;
      diag_q <= 1'b0;
      cold_pend_q <= 1'b1;
    end else begin
      cold_pend_q <= 1'b0;
      if (st_wr) begin
        exl_q <= wd[`EVP_ST_EXL];
        erl_q <= wd[`EVP_ST_ERL];
        bev_q <= wd[`EVP_ST_BEV];
        priv_q <= wd[`EVP_ST_PRIV_LO+1:`EVP_ST_PRIV_LO];
        diag_q <= wd[`EVP_ST_DIAG];
      end
      if (eret) begin
        exl_q <= 1'b0;
      end
      if (take) begin
        if (err_class) begin
          erl_q <= 1'b1;
        end else begin
          exl_q <= 1'b1;
        end
        if (is_reset) begin
          bev_q <= 1'b1;
        end
      end
    end
  end

  // Error level frozen: a second error must not lose the first address
  wire era_load = take & err_class & (cold_pend_q | !erl_q);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      era_q <= {AW{1'b0}};
    end else if (era_load) begin
      era_q <= in_delay_slot ? branch_pc : exc_pc;
    end else if (wr_now && wa_q == `EVP_OFF_ERA_LO) begin
      era_q[31:0] <= wd;
    end else if (wr_now && wa_q == `EVP_OFF_ERA_HI) begin
      era_q[AW-1:32] <= wd;
    end
  end

  // ----------------------------------------------------------------
  // Registered results
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_taken <= 1'b0;
      exc_code <= `EVP_CODE_NONE;
      vector_addr <= {AW{1'b0}};
      kernel_mode <= 1'b1;
      priv_mode <= `EVP_PRIV_KERNEL;
    end else begin
      exc_taken <= take;
      if (take) begin
        exc_code <= code;
        vector_addr <= sext(base + ofs, mode64);
      end
      // Mode lags the level bits by one cycle
      kernel_mode <= exl_q | erl_q | (priv_q == `EVP_PRIV_KERNEL);
      priv_mode <= (exl_q | erl_q) ? `EVP_PRIV_KERNEL : priv_q;
    end
  end

endmodule // evp_exception_unit
